// ---- hw/dma_mask_defines.vh ----
`ifndef DMA_MASK_DEFINES_VH
`define DMA_MASK_DEFINES_VH

`define IO_ADDR_W              8
`define MASK_ALL_LOW_ADDR      8'h0f
`define MASK_ALL_HIGH_ADDR     8'hde
`define SINGLE_MASK_LOW_ADDR   8'h0a
`define SINGLE_MASK_HIGH_ADDR  8'hd4
`define MASTER_CLEAR_LOW_ADDR  8'h0d
`define MASTER_CLEAR_HIGH_ADDR 8'hda
`define MASK_RESET             4'hf
`define MASK_LSB               0
`define MASK_MSB               3
`define SINGLE_SEL_LSB         0
`define SINGLE_SEL_MSB         1
`define SINGLE_VAL_BIT         2
`define CASCADE_CH             2'h0

`endif

// ---- hw/dma_mask_ctrl.v ----
`timescale 1ns/1ns
// One controller's four mask bits with their software and hardware updates.
`include "dma_mask_defines.vh"
module dma_mask_ctrl
(
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       all_we_i,
  input  wire       single_we_i,
  input  wire       mclr_i,
  input  wire [7:0] wdata_i,
  input  wire [3:0] tc_i,
  input  wire [3:0] autoinit_i,
  output reg  [3:0] mask_o
);

  reg     [3:0] mask_d;
  integer       n;

  always @*
  begin
    mask_d = mask_o;
    if (all_we_i)
      mask_d = wdata_i[`MASK_MSB:`MASK_LSB]; // R1 R9 R12
    else if (single_we_i)
    begin
      for (n = 0; n < 4; n = n + 1)
        if (wdata_i[`SINGLE_SEL_MSB:`SINGLE_SEL_LSB] == n[1:0])
          mask_d[n] = wdata_i[`SINGLE_VAL_BIT]; // R11
    end
    // Terminal count is applied after the software write so the set is never lost.
    mask_d = mask_d | (tc_i & ~autoinit_i); // R4
    if (mclr_i)
      mask_d = `MASK_RESET; // R10 R5
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mask_o <= `MASK_RESET; // R5
    else
      mask_o <= mask_d;
  end

endmodule

// ---- hw/dma_channel_mask_all.v ----
`timescale 1ns/1ns
// Functional notes
// [R1] Mask register write updates four channels together
// [R2] Set mask blocks request; clear passes it
// [R3] Read returns present mask in low nibble
// [R4] Terminal count sets mask unless autoinitialize
// [R5] Reset and master clear set all masks
// [R6] Masked channel 4 blocks channels 0-3
// [R7] Software writes zeros to upper four bits
// [R8] Low controller 0Fh, high controller DEh
// [R9] Bits 0-3 map to channels in order
// [R10] Master clear clears state, sets masks
// [R11] Single-mask write changes one selected channel
// [R12] Upper bits ignored on write, read zero
`include "dma_mask_defines.vh"
module dma_channel_mask_all
(
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [7:0] io_addr_i,
  input  wire [7:0] io_wdata_i,
  input  wire       io_wr_i,
  input  wire       io_rd_i,
  input  wire [7:0] channel_request_line_i,
  input  wire [7:0] tc_i,
  input  wire [7:0] autoinit_i,
  output reg  [7:0] io_rdata_o,
  output reg        io_rvalid_o,
  output reg  [7:0] request_gated_o,
  output reg  [7:0] mask_o,
  output reg  [1:0] master_clear_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Channel layout.

  localparam CH_PER_CTRL = 4;
  localparam NUM_CH      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Only the two all-channel mask registers answer a read.
  function mask_read;
    input [7:0] addr;
    begin
      mask_read = hit(addr, `MASK_ALL_LOW_ADDR) | hit(addr, `MASK_ALL_HIGH_ADDR); // R8
    end
  endfunction

  // Read word of one bank, with the reserved upper nibble held at zero.
  function [7:0] read_word;
    input [7:0] addr;
    input [3:0] lo;
    input [3:0] hi;
    begin
      if (hit(addr, `MASK_ALL_LOW_ADDR))
        read_word = {4'h0, lo}; // R3 R12
      else if (hit(addr, `MASK_ALL_HIGH_ADDR))
        read_word = {4'h0, hi}; // R3 R12
      else
        read_word = 8'h00;
    end
  endfunction

  wire       wr_all_lo = io_wr_i & hit(io_addr_i, `MASK_ALL_LOW_ADDR);     // R8
  wire       wr_all_hi = io_wr_i & hit(io_addr_i, `MASK_ALL_HIGH_ADDR);    // R8
  wire       wr_sgl_lo = io_wr_i & hit(io_addr_i, `SINGLE_MASK_LOW_ADDR);
  wire       wr_sgl_hi = io_wr_i & hit(io_addr_i, `SINGLE_MASK_HIGH_ADDR);
  wire       mclr_lo   = io_wr_i & hit(io_addr_i, `MASTER_CLEAR_LOW_ADDR); // R10
  wire       mclr_hi   = io_wr_i & hit(io_addr_i, `MASTER_CLEAR_HIGH_ADDR);
  wire       rd_mask   = io_rd_i & mask_read(io_addr_i);
  wire [3:0] mask_lo;
  wire [3:0] mask_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Request line synchronisers, two flip-flops per channel.

  wire [NUM_CH-1:0] req_sync;

  genvar ch;

  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1)
    begin : g_sync
      reg meta_q;
      reg sync_q;

      // The first stage may go metastable, so only the second stage is read.
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= channel_request_line_i[ch];
          sync_q <= meta_q;
        end
      end

      assign req_sync[ch] = sync_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Mask banks, one per controller.

  // Per-bank slices of the terminal count and autoinitialize inputs.
  wire [3:0] tc_lo       = tc_i[3:0];
  wire [3:0] tc_hi       = tc_i[7:4];
  wire [3:0] autoinit_lo = autoinit_i[3:0];
  wire [3:0] autoinit_hi = autoinit_i[7:4];

  // Both banks see every write data byte; the address decode picks the one that acts.
  dma_mask_ctrl u_lo
  (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .all_we_i    (wr_all_lo),
    .single_we_i (wr_sgl_lo),
    .mclr_i      (mclr_lo),
    .wdata_i     (io_wdata_i),
    .tc_i        (tc_lo),
    .autoinit_i  (autoinit_lo),
    .mask_o      (mask_lo)
  );

  dma_mask_ctrl u_hi
  (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .all_we_i    (wr_all_hi),
    .single_we_i (wr_sgl_hi),
    .mclr_i      (mclr_hi),
    .wdata_i     (io_wdata_i),
    .tc_i        (tc_hi),
    .autoinit_i  (autoinit_hi),
    .mask_o      (mask_hi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request gating.

  wire [NUM_CH-1:0] mask_all = {mask_hi, mask_lo};
  wire [NUM_CH-1:0] req_pass;

  // Channel 4 carries the whole low controller, so its mask gates all of it.
  wire              cascade_shut = mask_hi[`CASCADE_CH]; // R6

  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1)
    begin : g_gate
      if (ch < CH_PER_CTRL)
      begin : g_low
        assign req_pass[ch] = req_sync[ch] & ~mask_all[ch] & ~cascade_shut; // R2 R6
      end
      else
      begin : g_high
        assign req_pass[ch] = req_sync[ch] & ~mask_all[ch]; // R2
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path, registered.

  // Read data is zero between reads, so a stale mask never looks like an answer.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end
    else
    begin
      io_rvalid_o <= rd_mask; // R8
      if (io_rd_i)
        io_rdata_o <= read_word(io_addr_i, mask_lo, mask_hi); // R3 R12
      else
        io_rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask copy and gated requests, registered.

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mask_o          <= 8'hff;
      request_gated_o <= 8'h00;
    end
    else
    begin
      mask_o          <= mask_all; // R3
      request_gated_o <= req_pass; // R2 R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clear pulse to the rest of the controller.

  // The pulse lets the command, status and request logic clear alongside the masks.
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      master_clear_o <= 2'h0;
    else
      master_clear_o <= {mclr_hi, mclr_lo}; // R10
  end

endmodule

// ---- bench/dma_mask_props.sv ----
`timescale 1ns/1ns
module dma_mask_props
(
  input wire       clk_i,
  input wire       nrst_i,
  input wire [7:0] io_addr_i,
  input wire [7:0] io_wdata_i,
  input wire       io_wr_i,
  input wire       io_rd_i,
  input wire [7:0] tc_i,
  input wire [7:0] autoinit_i,
  input wire [7:0] io_rdata_o,
  input wire       io_rvalid_o,
  input wire [7:0] request_gated_o,
  input wire [7:0] mask_o,
  input wire [1:0] master_clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rl; io_rd_i && io_addr_i==8'h0f |=> io_rvalid_o && io_rdata_o=={4'h0,mask_o[3:0]};
  endproperty
  a_rl: assert property (p_rl) else $error("low read");
  property p_rh; io_rd_i && io_addr_i==8'hde |=> io_rvalid_o && io_rdata_o=={4'h0,mask_o[7:4]};
  endproperty
  a_rh: assert property (p_rh) else $error("high read");
  property p_un; io_rd_i && io_addr_i!=8'h0f && io_addr_i!=8'hde |=> !io_rvalid_o; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_wr; io_wr_i && io_addr_i==8'h0f && tc_i==8'h00
    |=> ##1 mask_o[3:0]==$past(io_wdata_i[3:0],2); endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_gt; (request_gated_o & mask_o)==8'h00; endproperty
  a_gt: assert property (p_gt) else $error("gate");
  property p_cs; mask_o[4] |-> request_gated_o[3:0]==4'h0; endproperty
  a_cs: assert property (p_cs) else $error("cascade");
  property p_tc; tc_i[1] && !autoinit_i[1] |-> ##2 mask_o[1]; endproperty
  a_tc: assert property (p_tc) else $error("terminal count");
  property p_mc; io_wr_i && io_addr_i==8'h0d |-> ##2 mask_o[3:0]==4'hf; endproperty
  a_mc: assert property (p_mc) else $error("master clear");
  property p_mo; io_wr_i && io_addr_i==8'hda |=> master_clear_o==2'h2; endproperty
  a_mo: assert property (p_mo) else $error("high master clear pulse");
  property p_mh; io_wr_i && io_addr_i==8'hda |-> ##2 mask_o[7:4]==4'hf; endproperty
  a_mh: assert property (p_mh) else $error("high master clear");
endmodule
bind dma_channel_mask_all dma_mask_props u_props
(
  .clk_i           (clk_i),
  .nrst_i          (nrst_i),
  .io_addr_i       (io_addr_i),
  .io_wdata_i      (io_wdata_i),
  .io_wr_i         (io_wr_i),
  .io_rd_i         (io_rd_i),
  .tc_i            (tc_i),
  .autoinit_i      (autoinit_i),
  .io_rdata_o      (io_rdata_o),
  .io_rvalid_o     (io_rvalid_o),
  .request_gated_o (request_gated_o),
  .mask_o          (mask_o),
  .master_clear_o  (master_clear_o)
);

// ---- bench/dma_req_model.sv ----
`timescale 1ns/1ns
module dma_req_model
(
  input  wire       clk_i,
  input  wire [7:0] want_i,
  output reg  [7:0] req_o
);
  always @(posedge clk_i) req_o <= #1 want_i;
endmodule

// ---- bench/dma_channel_mask_all_tb.sv ----
`timescale 1ns/1ns
module dma_channel_mask_all_tb;
  reg clk_i = 0, nrst_i = 0, wr = 0, rd = 0;
  reg [7:0] a = 0, d = 0, tc = 0, ai = 0, want = 0;
  wire [7:0] rq, rdat, rg, m;
  wire [1:0] mc;
  wire rv;
  int errors = 0, total_checks = 0, cyc = 0;
  dma_req_model peer (.clk_i(clk_i), .want_i(want), .req_o(rq));
  dma_channel_mask_all DUT (.clk_i(clk_i), .nrst_i(nrst_i), .io_addr_i(a), .io_wdata_i(d),
    .io_wr_i(wr), .io_rd_i(rd), .channel_request_line_i(rq), .tc_i(tc), .autoinit_i(ai),
    .io_rdata_o(rdat), .io_rvalid_o(rv), .request_gated_o(rg), .mask_o(m), .master_clear_o(mc));
  initial forever #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task summarize;
  begin
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  task ck(input string n, input [7:0] e, input [7:0] s);
  begin
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  end
  endtask
  task w(input [7:0] ad, input [7:0] dt);
  begin
    @(posedge clk_i) #1 a = ad;
    d = dt;
    wr = 1;
    @(posedge clk_i) #1 wr = 0;
  end
  endtask
  task r(input [7:0] ad, input [7:0] e);
  begin
    @(posedge clk_i) #1 a = ad;
    rd = 1;
    @(posedge clk_i) #1 rd = 0;
    ck("rdata", e, rdat);
    ck("rvalid", {7'h00, ad == 8'h0f || ad == 8'hde}, {7'h00, rv});
  end
  endtask
  always @(posedge clk_i) if (++cyc > 2000)
  begin
    errors++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1;
    r(8'h0f, 8'h0f);
    r(8'hde, 8'h0f);
    ck("mask", 8'hff, m);
    w(8'h0f, 8'hf5);
    r(8'h0f, 8'h05);
    w(8'hde, 8'h0a);
    r(8'hde, 8'h0a);
    r(8'h10, 8'h00);
    want = 8'hff;
    repeat (5) @(posedge clk_i);
    #1 ck("gated", 8'h5a, rg);
    w(8'hde, 8'h01);
    repeat (4) @(posedge clk_i);
    #1 ck("cascade", 8'he0, rg);
    @(posedge clk_i) #1 tc = 8'h0a;
    ai = 8'h08;
    @(posedge clk_i) #1 tc = 8'h00;
    r(8'h0f, 8'h07);
    w(8'h0a, 8'h00);
    r(8'h0f, 8'h06);
    w(8'h0d, 8'h00);
    ck("mclr", 8'h01, {6'h00, mc});
    r(8'h0f, 8'h0f);
    w(8'hde, 8'h00);
    w(8'hd4, 8'h06);
    r(8'hde, 8'h04);
    w(8'hda, 8'h00);
    ck("mclr", 8'h02, {6'h00, mc});
    r(8'hde, 8'h0f);
    w(8'h0f, 8'h00);
    w(8'hde, 8'h00);
    nrst_i = 0;
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1;
    r(8'h0f, 8'h0f);
    r(8'hde, 8'h0f);
    summarize;
  end
endmodule
